// >>> hw/srcs_ref_sample.sv
// Samples the reference on the chosen clock edge and flags the qualifying transition.
// Assumes refIn is synchronous to clk and sampleTick comes from the input clock divider.
`timescale 1ns/10ps

module srcs_ref_sample
  import srcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Reference and controls
  input wire logic refIn,
  input wire logic fallingEdgeSel,
  input wire logic highToLowSel,
  input wire logic sampleTick,
  // Result
  output logic qualEvent
);

  logic riseSample_ff;
  logic fallSample_ff;
  logic fallRetime_ff;
  logic curLevel_ff;
  logic prevLevel_ff;
  logic pickedLevel;
  logic lowToHigh;
  logic highToLow;

  always_ff @(posedge clk) begin
    if (reset) riseSample_ff <= 1'b0;
    else riseSample_ff <= refIn;
  end

  // Falling edge capture is retimed at once so the rest of the block stays on one edge
  always_ff @(negedge clk) begin
    if (reset) fallSample_ff <= 1'b0;
    else fallSample_ff <= refIn;
  end

  always_ff @(posedge clk) begin
    if (reset) fallRetime_ff <= 1'b0;
    else fallRetime_ff <= fallSample_ff;
  end

  assign pickedLevel = fallingEdgeSel ? fallRetime_ff : riseSample_ff;

  // Levels compared only on divider ticks, hence the stretched pulse width demanded of the source
  always_ff @(posedge clk) begin
    if (reset) begin
      curLevel_ff <= 1'b0;
      prevLevel_ff <= 1'b0;
    end else if (sampleTick) begin
      curLevel_ff <= pickedLevel;
      prevLevel_ff <= curLevel_ff;
    end
  end

  assign lowToHigh = curLevel_ff & ~prevLevel_ff;
  assign highToLow = ~curLevel_ff & prevLevel_ff;
  // One pulse per tick window: only valid in the cycle after the tick updated the levels
  logic tickSeen_ff;
  always_ff @(posedge clk) begin
    if (reset) tickSeen_ff <= 1'b0;
    else tickSeen_ff <= sampleTick;
  end
  assign qualEvent = tickSeen_ff & (highToLowSel ? highToLow : lowToHigh);

endmodule : srcs_ref_sample

// >>> hw/srcs_top.sv
// Reference capture and alignment: registers, capture state machine, divider and LMFC.
// Assumes a byte-wide register port driven synchronously to clk and a clean clk.
`timescale 1ns/10ps

module srcs_top
  import srcs_pkg::*;
#(
  parameter int LMFC_S = `SRCS_LMFC_S,
  parameter int LMFC_K = `SRCS_LMFC_K,
  parameter int TAPS = `SRCS_TAPS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [`SRCS_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [`SRCS_DATA_W-1:0] regWrData,
  input wire logic regRdEn,
  output srcs_byte_type regRdData_ff,
  // Reference input and window taps
  input wire logic sysrefIn,
  input wire logic [TAPS-1:0] refSetupTaps,
  input wire logic [TAPS-1:0] refHoldTaps,
  // Alignment strobes
  output logic syncDivider_ff,
  output logic syncDdc_ff,
  output logic syncSigMon_ff,
  output logic syncLink_ff,
  output logic sampleTick,
  output logic lmfcTick_ff,
  // Window status
  output logic refCaptured,
  output logic setupViolation,
  output logic holdViolation,
  output logic setupOrHoldViolation
);

  localparam int LMFC_LEN = LMFC_S * LMFC_K;
  localparam int LMFC_W = (LMFC_LEN > 1) ? $clog2(LMFC_LEN) : 1;
  localparam logic [LMFC_W-1:0] LMFC_LAST = LMFC_W'(LMFC_LEN - 1);

  // Register storage
  srcs_byte_type clkDiv_ff;
  srcs_byte_type refCtrl_ff;
  srcs_byte_type ignCnt_ff;
  srcs_byte_type syncMode_ff;
  srcs_byte_type subclass_ff;
  srcs_byte_type nxt_refCtrl;
  srcs_byte_type nxt_rdData;
  srcs_byte_type winMonByte;

  // Decode
  logic selClkDiv;
  logic selRefCtrl;
  logic selIgnCnt;
  logic selWinMon;
  logic selSyncMode;
  logic selSubclass;
  logic wrClkDiv;
  logic wrRefCtrl;
  logic wrIgnCnt;
  logic wrSyncMode;
  logic wrSubclass;

  assign selClkDiv = (regAddr == `SRCS_OFF_CLK_DIV);
  assign selRefCtrl = (regAddr == `SRCS_OFF_REF_CTRL);
  assign selIgnCnt = (regAddr == `SRCS_OFF_IGN_CNT);
  assign selWinMon = (regAddr == `SRCS_OFF_WIN_MON);
  assign selSyncMode = (regAddr == `SRCS_OFF_SYNC_MODE);
  assign selSubclass = (regAddr == `SRCS_OFF_SUBCLASS);
  assign wrClkDiv = regWrEn & selClkDiv;
  assign wrRefCtrl = regWrEn & selRefCtrl;
  assign wrIgnCnt = regWrEn & selIgnCnt;
  assign wrSyncMode = regWrEn & selSyncMode;
  assign wrSubclass = regWrEn & selSubclass;

  // Field views
  logic [1:0] refMode;
  logic fallingEdgeSel;
  logic highToLowSel;
  logic [2:0] divSel;
  logic [3:0] ignoreCount;
  logic timestampMode;
  logic [2:0] subclassSel;
  logic refUsed;

  assign refMode = refCtrl_ff[`SRCS_MODE_MSB:`SRCS_MODE_LSB];
  assign fallingEdgeSel = refCtrl_ff[`SRCS_EDGE_BIT];
  assign highToLowSel = refCtrl_ff[`SRCS_TRANS_BIT];
  assign divSel = clkDiv_ff[`SRCS_DIV_MSB:`SRCS_DIV_LSB];
  assign ignoreCount = ignCnt_ff[`SRCS_IGN_MSB:`SRCS_IGN_LSB];
  assign timestampMode = syncMode_ff[`SRCS_SYNC_BIT];
  assign subclassSel = subclass_ff[`SRCS_SUB_MSB:`SRCS_SUB_LSB];
  assign refUsed = (subclassSel != `SRCS_SUB_CLASS0);

  // Capture state machine
  srcs_state_type state_ff;
  srcs_state_type nxt_state;
  logic [3:0] skipCnt_ff;
  logic [3:0] nxt_skipCnt;
  logic qualEvent;
  logic actEvent;
  logic modeSelfClear;
  logic realign;

  always_comb begin
    nxt_state = state_ff;
    nxt_skipCnt = skipCnt_ff;
    actEvent = 1'b0;
    modeSelfClear = 1'b0;
    case (state_ff)
      SRCS_IDLE: begin
        if (refMode == `SRCS_MODE_CONT) begin
          nxt_state = SRCS_RUN;
        end else if (refMode == `SRCS_MODE_NSHOT) begin
          nxt_skipCnt = ignoreCount;
          nxt_state = (ignoreCount == 4'h0) ? SRCS_WAIT : SRCS_SKIP;
        end
      end
      SRCS_SKIP: begin
        if (refMode != `SRCS_MODE_NSHOT) begin
          nxt_state = SRCS_IDLE;
        end else if (qualEvent) begin
          nxt_skipCnt = skipCnt_ff - 4'h1;
          if (skipCnt_ff == 4'h1) nxt_state = SRCS_WAIT;
        end
      end
      SRCS_WAIT: begin
        if (refMode != `SRCS_MODE_NSHOT) begin
          nxt_state = SRCS_IDLE;
        end else if (qualEvent) begin
          actEvent = 1'b1;
          modeSelfClear = 1'b1;
          nxt_state = SRCS_IDLE;
        end
      end
      SRCS_RUN: begin
        if (refMode != `SRCS_MODE_CONT) begin
          nxt_state = SRCS_IDLE;
        end else if (qualEvent) begin
          actEvent = 1'b1;
        end
      end
      default: begin
        nxt_state = SRCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= SRCS_IDLE;
      skipCnt_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      skipCnt_ff <= nxt_skipCnt;
    end
  end

  // A software write in the clearing cycle wins so a re-arm is never lost
  always_comb begin
    nxt_refCtrl = refCtrl_ff;
    if (wrRefCtrl) begin
      nxt_refCtrl = regWrData;
    end else if (modeSelfClear) begin
      nxt_refCtrl[`SRCS_MODE_MSB:`SRCS_MODE_LSB] = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      clkDiv_ff <= `SRCS_RST_CLK_DIV;
      refCtrl_ff <= `SRCS_RST_REF_CTRL;
      ignCnt_ff <= `SRCS_RST_IGN_CNT;
      syncMode_ff <= `SRCS_RST_SYNC_MODE;
      subclass_ff <= `SRCS_RST_SUBCLASS;
    end else begin
      refCtrl_ff <= nxt_refCtrl;
      if (wrClkDiv) clkDiv_ff <= regWrData;
      if (wrIgnCnt) ignCnt_ff <= regWrData;
      if (wrSyncMode) syncMode_ff <= regWrData;
      if (wrSubclass) subclass_ff <= regWrData;
    end
  end

  // Realignment only in normal sync mode; timestamp mode leaves the clocks alone
  assign realign = actEvent & ~timestampMode & refUsed;

  // Input clock divider; ratio is the field value plus one
  logic [2:0] divCnt_ff;
  logic [2:0] nxt_divCnt;

  assign sampleTick = (divCnt_ff == 3'h0);
  assign nxt_divCnt = (realign || divCnt_ff >= divSel) ? 3'h0 : divCnt_ff + 3'h1;

  always_ff @(posedge clk) begin
    if (reset) divCnt_ff <= 3'h0;
    else divCnt_ff <= nxt_divCnt;
  end

  // LMFC counts divided sample ticks over S times K
  logic [LMFC_W-1:0] lmfcCnt_ff;
  logic [LMFC_W-1:0] nxt_lmfcCnt;
  logic lmfcWrap;

  assign lmfcWrap = sampleTick & (lmfcCnt_ff == LMFC_LAST);
  assign nxt_lmfcCnt = realign ? '0 :
    (lmfcWrap ? '0 : (sampleTick ? lmfcCnt_ff + LMFC_W'(1) : lmfcCnt_ff));

  always_ff @(posedge clk) begin
    if (reset) begin
      lmfcCnt_ff <= '0;
      lmfcTick_ff <= 1'b0;
    end else begin
      lmfcCnt_ff <= nxt_lmfcCnt;
      lmfcTick_ff <= realign | lmfcWrap;
    end
  end

  // Alignment strobes to the downstream blocks
  always_ff @(posedge clk) begin
    if (reset) begin
      syncDivider_ff <= 1'b0;
      syncDdc_ff <= 1'b0;
      syncSigMon_ff <= 1'b0;
      syncLink_ff <= 1'b0;
    end else begin
      syncDivider_ff <= realign;
      syncDdc_ff <= realign;
      syncSigMon_ff <= realign;
      syncLink_ff <= realign;
    end
  end

  srcs_ref_sample u_sample (
    .clk(clk),
    .reset(reset),
    .refIn(sysrefIn),
    .fallingEdgeSel(fallingEdgeSel),
    .highToLowSel(highToLowSel),
    .sampleTick(sampleTick),
    .qualEvent(qualEvent)
  );

  srcs_code_type setupCode;
  srcs_code_type holdCode;

  srcs_window_mon #(
    .TAPS(TAPS)
  ) u_window (
    .clk(clk),
    .reset(reset),
    .capture(actEvent),
    .setupTaps(refSetupTaps),
    .holdTaps(refHoldTaps),
    .setupCode_ff(setupCode),
    .holdCode_ff(holdCode),
    .captured_ff(refCaptured),
    .setupViolation(setupViolation),
    .holdViolation(holdViolation),
    .eitherViolation(setupOrHoldViolation)
  );

  assign winMonByte = {holdCode, setupCode};

  // Read mux; unmapped offsets read zero
  assign nxt_rdData = selClkDiv ? clkDiv_ff :
    selRefCtrl ? refCtrl_ff :
    selIgnCnt ? ignCnt_ff :
    selWinMon ? winMonByte :
    selSyncMode ? syncMode_ff :
    selSubclass ? subclass_ff : `SRCS_RD_UNMAPPED;

  always_ff @(posedge clk) begin
    if (reset) regRdData_ff <= `SRCS_RD_UNMAPPED;
    else if (regRdEn) regRdData_ff <= nxt_rdData;
  end

endmodule : srcs_top

// >>> hw/srcs_window_mon.sv
// Setup and hold detectors of the reference capture window, latched on each capture.
// Assumes tap vectors come from a delay line around the capturing edge, bit 0 nearest it.
`timescale 1ns/10ps

module srcs_window_mon
  import srcs_pkg::*;
#(
  parameter int TAPS = `SRCS_TAPS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Detector inputs
  input wire logic capture,
  input wire logic [TAPS-1:0] setupTaps,
  input wire logic [TAPS-1:0] holdTaps,
  // Status
  output srcs_code_type setupCode_ff,
  output srcs_code_type holdCode_ff,
  output logic captured_ff,
  output logic setupViolation,
  output logic holdViolation,
  output logic eitherViolation
);

  function automatic srcs_code_type count_taps(input logic [TAPS-1:0] taps);
    srcs_code_type n;
    n = 4'h0;
    for (int i = 0; i < TAPS; i++) begin
      n = n + {3'h0, taps[i]};
    end
    return n;
  endfunction : count_taps

  srcs_code_type nxt_setupCode;
  srcs_code_type nxt_holdCode;

  assign nxt_setupCode = count_taps(setupTaps);
  assign nxt_holdCode = count_taps(holdTaps);

  always_ff @(posedge clk) begin
    if (reset) begin
      setupCode_ff <= 4'h0;
      holdCode_ff <= 4'h0;
      captured_ff <= 1'b0;
    end else if (capture) begin
      setupCode_ff <= nxt_setupCode;
      holdCode_ff <= nxt_holdCode;
      captured_ff <= 1'b1;
    end
  end

  // Codes that match no row of the interpretation, or no capture yet, flag nothing
  assign setupViolation = captured_ff & (holdCode_ff == 4'h0) & (setupCode_ff != 4'h0)
    & (setupCode_ff <= `SRCS_CODE_SETUP_MAX);
  assign holdViolation = captured_ff & (setupCode_ff == 4'h0)
    & (holdCode_ff >= `SRCS_CODE_HOLD_MIN);
  assign eitherViolation = captured_ff & (setupCode_ff == 4'h0) & (holdCode_ff == 4'h0);

endmodule : srcs_window_mon

// >>> pkg/srcs_map.svh
// Register offsets, field positions, reset values and counts of the reference capture block.
// Included by the package, not by the design modules; definitions only.
`ifndef SRCS_MAP_SVH
`define SRCS_MAP_SVH

`define SRCS_ADDR_W 12
`define SRCS_DATA_W 8

`define SRCS_OFF_CLK_DIV 12'h10b
`define SRCS_OFF_REF_CTRL 12'h120
`define SRCS_OFF_IGN_CNT 12'h121
`define SRCS_OFF_WIN_MON 12'h128
`define SRCS_OFF_SYNC_MODE 12'h1ff
`define SRCS_OFF_SUBCLASS 12'h590

`define SRCS_RST_CLK_DIV 8'h00
`define SRCS_RST_REF_CTRL 8'h00
`define SRCS_RST_IGN_CNT 8'h00
`define SRCS_RST_SYNC_MODE 8'h00
`define SRCS_RST_SUBCLASS 8'h20
`define SRCS_RD_UNMAPPED 8'h00

`define SRCS_DIV_LSB 0
`define SRCS_DIV_MSB 2
`define SRCS_MODE_LSB 1
`define SRCS_MODE_MSB 2
`define SRCS_EDGE_BIT 3
`define SRCS_TRANS_BIT 4
`define SRCS_IGN_LSB 0
`define SRCS_IGN_MSB 3
`define SRCS_SYNC_BIT 0
`define SRCS_SUB_LSB 5
`define SRCS_SUB_MSB 7

`define SRCS_MODE_CONT 2'h1
`define SRCS_MODE_NSHOT 2'h2
`define SRCS_SUB_CLASS0 3'h0

`define SRCS_TAPS 15
`define SRCS_CODE_MID 4'h8
`define SRCS_CODE_SETUP_MAX 4'h7
`define SRCS_CODE_HOLD_MIN 4'h9

`define SRCS_LMFC_S 1
`define SRCS_LMFC_K 32

`endif

// >>> pkg/srcs_pkg.sv
// Types shared by the reference capture modules.
// Assumes srcs_map.svh sits on the include path.
`include "srcs_map.svh"

package srcs_pkg;

  typedef enum logic [1:0] {
    SRCS_IDLE,
    SRCS_SKIP,
    SRCS_WAIT,
    SRCS_RUN
  } srcs_state_type;

  typedef logic [`SRCS_DATA_W-1:0] srcs_byte_type;
  typedef logic [3:0] srcs_code_type;

endpackage : srcs_pkg

// >>> verif/srcs_ref_source.sv
// Model of the clock generator that drives the reference pulse.
// Assumes fire is raised for one cycle just after a rising edge.
`timescale 1ns/10ps

module srcs_ref_source (
  // Clock
  input wire logic clk,
  // Request
  input wire logic fire,
  input wire logic [7:0] width,
  // Reference
  output logic refOut
);
  initial begin
    refOut = 1'b0;
    forever begin
      @(posedge clk);
      if (fire === 1'b1) begin
        #1 refOut = 1'b1;
        // Whole clock periods, already scaled by the divide ratio
        repeat (width) @(posedge clk);
        #1 refOut = 1'b0;
      end
    end
  end
endmodule : srcs_ref_source

// >>> verif/srcs_top_asserts.sv
// Port-level checker of the reference capture block.
// Assumes the port names of srcs_top; bound at the foot of this file.
`timescale 1ns/10ps

module srcs_top_asserts
  import srcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [`SRCS_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [`SRCS_DATA_W-1:0] regWrData,
  input wire logic regRdEn,
  input srcs_byte_type regRdData_ff,
  // Strobes and status
  input wire logic syncDivider_ff,
  input wire logic syncDdc_ff,
  input wire logic syncSigMon_ff,
  input wire logic syncLink_ff,
  input wire logic refCaptured,
  input wire logic setupViolation,
  input wire logic holdViolation,
  input wire logic setupOrHoldViolation
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_div_wr;
    regWrEn && regAddr == `SRCS_OFF_CLK_DIV;
  endsequence
  sequence s_div_rd;
    regRdEn && regAddr == `SRCS_OFF_CLK_DIV;
  endsequence

  chk_sync_all_blocks: assert property (
    (syncDivider_ff || syncDdc_ff || syncSigMon_ff || syncLink_ff)
      |-> (syncDivider_ff && syncDdc_ff && syncSigMon_ff && syncLink_ff))
    else $error("realign strobes disagree");
  chk_sync_one_cycle: assert property (syncDivider_ff |=> !syncDivider_ff)
    else $error("realign strobe longer than one cycle");
  chk_capture_sticky: assert property (refCaptured |=> refCaptured)
    else $error("captured flag dropped");
  chk_sync_sets_captured: assert property (syncDivider_ff |=> refCaptured)
    else $error("realign without captured flag");
  chk_flags_onehot: assert property (
    $onehot0({setupViolation, holdViolation, setupOrHoldViolation}))
    else $error("violation flags overlap");
  chk_flags_need_capture: assert property (
    (setupViolation || holdViolation || setupOrHoldViolation) |-> refCaptured)
    else $error("violation flag before capture");
  chk_unmapped_read: assert property (
    regRdEn && regAddr == 12'h7ff |=> regRdData_ff == `SRCS_RD_UNMAPPED)
    else $error("unmapped read not zero");
  chk_div_readback: assert property (
    s_div_wr ##1 s_div_rd |=> regRdData_ff[2:0] == $past(regWrData[2:0], 2))
    else $error("divider field readback wrong");
  chk_read_holds: assert property (!regRdEn |=> $stable(regRdData_ff))
    else $error("read data changed without read");
endmodule : srcs_top_asserts

bind srcs_top srcs_top_asserts srcs_top_asserts_inst (
  .clk(clk), .reset(reset), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff),
  .syncDivider_ff(syncDivider_ff), .syncDdc_ff(syncDdc_ff),
  .syncSigMon_ff(syncSigMon_ff), .syncLink_ff(syncLink_ff), .refCaptured(refCaptured),
  .setupViolation(setupViolation), .holdViolation(holdViolation),
  .setupOrHoldViolation(setupOrHoldViolation)
);

// >>> verif/tb_srcs_top.sv
// Self-checking bench of the reference capture block.
// Assumes srcs_top, the checker and the reference source model are compiled first.
`timescale 1ns/10ps

module tb_srcs_top;
  import srcs_pkg::*;
  logic clk, reset, regWrEn, regRdEn, sysrefIn, fire;
  logic [11:0] regAddr;
  logic [7:0] regWrData, width, q;
  logic [14:0] refSetupTaps, refHoldTaps;
  srcs_byte_type regRdData_ff;
  logic syncDivider_ff, syncDdc_ff, syncSigMon_ff, syncLink_ff, sampleTick, lmfcTick_ff;
  logic refCaptured, setupViolation, holdViolation, setupOrHoldViolation;
  int mismatches = 0, comparisons = 0, cycle = 0, syncs = 0, hiSyncs = 0, tickAt, s0, h0;
  int ticks = 0;
  time wrDrop = 0, rdDrop = 0;

  srcs_top srcs_top_inst (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff),
    .sysrefIn(sysrefIn), .refSetupTaps(refSetupTaps), .refHoldTaps(refHoldTaps),
    .syncDivider_ff(syncDivider_ff), .syncDdc_ff(syncDdc_ff), .syncSigMon_ff(syncSigMon_ff),
    .syncLink_ff(syncLink_ff), .sampleTick(sampleTick), .lmfcTick_ff(lmfcTick_ff),
    .refCaptured(refCaptured), .setupViolation(setupViolation),
    .holdViolation(holdViolation), .setupOrHoldViolation(setupOrHoldViolation));
  srcs_ref_source srcs_ref_source_inst (.clk(clk), .fire(fire), .width(width),
    .refOut(sysrefIn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycle++;
    if (syncDivider_ff === 1'b1) syncs++;
    if (sampleTick === 1'b1) ticks++;
    if (syncDivider_ff === 1'b1 && sysrefIn === 1'b1) hiSyncs++;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (e !== g) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Tasks are entered just after a rising edge and return the same way
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // A strobe is never raised in the step that lowered it; one idle edge goes between
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    if (wrDrop == $time) cyc(1);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    cyc(1);
    regWrEn = 1'b0;
    wrDrop = $time;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    if (rdDrop == $time) cyc(1);
    regAddr = a;
    regRdEn = 1'b1;
    cyc(1);
    regRdEn = 1'b0;
    rdDrop = $time;
    q = regRdData_ff;
  endtask : rd
  // One pulse each 64 cycles, a whole number of 32-cycle multiframes
  task automatic pulse(input logic [7:0] w);
    width = w;
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    cyc(63);
  endtask : pulse
  task automatic arm(input logic [7:0] v);
    wr(12'h120, v);
    cyc(2);
    s0 = syncs;
    h0 = hiSyncs;
  endtask : arm
  task automatic wait_lmfc;
    int i;
    for (i = 0; i < 400; i++) begin
      if (lmfcTick_ff === 1'b1) break;
      cyc(1);
    end
    if (i == 400) begin
      mismatches++;
      $display("wrong value lmfc tick expected 1 seen 0");
      final_report;
    end
    tickAt = cycle;
    cyc(1);
  endtask : wait_lmfc

  task automatic t_reset;
    logic [11:0] a [7] = '{12'h10b, 12'h120, 12'h121, 12'h1ff, 12'h590, 12'h128, 12'h7ff};
    logic [7:0] v [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      rd(a[i]);
      chk("reset value", v[i], q);
    end
    chk("captured", 8'h00, {7'h0, refCaptured});
    $display("reset values done");
  endtask : t_reset
  task automatic t_nshot(input logic [7:0] n);
    wr(12'h121, n);
    arm(8'h04);
    repeat (n) pulse(8'h02);
    chk("skipped", 8'h00, 8'(syncs - s0));
    pulse(8'h02);
    chk("acted", 8'h01, 8'(syncs - s0));
    rd(12'h120);
    chk("mode cleared", 8'h00, {6'h0, q[2:1]});
    // Later scenarios arm single-shot and expect no skipped events
    wr(12'h121, 8'h00);
    $display("nshot %0d done", n);
  endtask : t_nshot
  task automatic t_cont;
    arm(8'h02);
    repeat (3) pulse(8'h08);
    chk("continuous", 8'h03, 8'(syncs - s0));
    rd(12'h120);
    chk("mode kept", 8'h01, {6'h0, q[2:1]});
    wr(12'h120, 8'h00);
    $display("continuous done");
  endtask : t_cont
  task automatic t_edges;
    for (int k = 0; k < 4; k++) begin
      arm(8'h04 | 8'(k << 3));
      pulse(8'h08);
      chk("edge acted", 8'h01, 8'(syncs - s0));
      chk("inside pulse", (k < 2) ? 8'h01 : 8'h00, 8'(hiSyncs - h0));
    end
    $display("edges done");
  endtask : t_edges
  task automatic t_off;
    logic [11:0] a [2] = '{12'h1ff, 12'h590};
    logic [7:0] v [2] = '{8'h01, 8'h00};
    logic [7:0] r [2] = '{8'h00, 8'h20};
    for (int i = 0; i < 2; i++) begin
      wr(a[i], v[i]);
      arm(8'h04);
      pulse(8'h08);
      chk("no realign", 8'h00, 8'(syncs - s0));
      rd(12'h120);
      chk("mode cleared", 8'h00, {6'h0, q[2:1]});
      wr(a[i], r[i]);
    end
    $display("realign off done");
  endtask : t_off
  task automatic t_lmfc;
    for (int d = 0; d < 2; d++) begin
      wr(12'h10b, 8'(d));
      rd(12'h10b);
      chk("divider", 8'(d), {5'h0, q[2:0]});
      wait_lmfc;
      wait_lmfc;
      s0 = tickAt;
      h0 = ticks;
      wait_lmfc;
      chk("lmfc period", 8'(32 * (d + 1)), 8'(tickAt - s0));
      chk("sample ticks", 8'h20, 8'(ticks - h0));
    end
    wr(12'h10b, 8'h00);
    $display("lmfc done");
  endtask : t_lmfc
  task automatic t_window;
    logic [3:0] h [4] = '{4'h0, 4'hc, 4'h0, 4'h4};
    logic [3:0] s [4] = '{4'h3, 4'h0, 4'h0, 4'h8};
    logic [2:0] f [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
    for (int i = 0; i < 4; i++) begin
      refHoldTaps = (15'h1 << h[i]) - 15'h1;
      refSetupTaps = (15'h1 << s[i]) - 15'h1;
      arm(8'h04);
      pulse(8'h08);
      rd(12'h128);
      chk("monitor", {h[i], s[i]}, q);
      chk("flags", {5'h0, f[i]}, {5'h0, setupViolation, holdViolation,
        setupOrHoldViolation});
    end
    $display("window done");
  endtask : t_window

  initial begin
    reset = 1'b1;
    {regRdEn, regWrEn, fire} = 3'h0;
    regAddr = 12'h000;
    regWrData = 8'h00;
    width = 8'h02;
    refSetupTaps = 15'h00ff;
    refHoldTaps = 15'h0000;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    t_reset;
    t_nshot(8'h00);
    t_nshot(8'h03);
    t_nshot(8'h0f);
    t_cont;
    t_edges;
    t_off;
    t_lmfc;
    t_window;
    final_report;
  end
endmodule : tb_srcs_top
